// *** design/ptp_stamp_pkg.sv ***
package ptp_stamp_pkg;
  // ==========================================================
  // stream framing
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] POS_ETYPE_HI = 16'h000c;
  localparam logic [15:0] POS_ETYPE_LO = 16'h000d;
  localparam logic [15:0] POS_MSGTYPE = 16'h000e;
  localparam logic [15:0] POS_DOMAIN = 16'h0012;
  localparam logic [15:0] POS_CORR = 16'h0016;
  localparam logic [15:0] POS_RSVD = 16'h001e;
  localparam logic [15:0] POS_ORIGIN = 16'h0022;
  localparam logic [15:0] POS_ORIGIN_END = 16'h002c;
  localparam logic [15:0] CORR_BYTES = 16'h0008;
  localparam logic [15:0] RSVD_BYTES = 16'h0004;
  localparam logic [15:0] ORIGIN_BYTES = 16'h000a;
  localparam logic [7:0] ETYPE_HI = 8'h88;
  localparam logic [7:0] ETYPE_LO = 8'hf7;
  localparam logic [3:0] MSG_SYNC = 4'h0;
  localparam logic [3:0] MSG_DELAY_REQ = 4'h1;
  // ==========================================================
  // time arithmetic
  localparam logic [29:0] NS_PER_SEC = 30'h3b9aca00;
  localparam logic [29:0] TICK_NS = 30'h00000008;
  localparam logic [29:0] EGR_LATENCY_NS = 30'h00000000;
  localparam logic [29:0] ING_LOCAL_CORR_NS = 30'h00000000;
  localparam int CORR_FRAC_BITS = 16;
  // ==========================================================
  // directions and rewrite actions
  localparam int DIR_EGR = 0;
  localparam int DIR_ING = 1;
  typedef enum logic [1:0] {ACT_NOP, ACT_RSVD, ACT_CORR, ACT_ORIGIN} action_t;
endpackage : ptp_stamp_pkg

// *** design/stream_fifo.sv ***
`timescale 1ns/1ns
module stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inWord,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outWord
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, rdPtr_q;
  logic [AW:0] count_q;
  logic push, pop;

  // ==========================================================
  // handshakes: full and empty come straight from the count
  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outWord = mem[rdPtr_q];

  // storage has no reset; only the pointers and the count need one
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inWord;
    end
  end

  // pointers wrap by index; depth is a power of two
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop)
      begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : stream_fifo

// *** design/ptp_one_step_stamper.sv ***
// Operation
// RULE1: master-side sync leaving for the line gets correction or full origin stamp
// RULE2: delay request arriving from the line is stamped before going inward
// RULE3: delay response is no event and passes both ways untouched
// RULE4: slave-side sync arriving from the line gets a receive stamp inserted
// RULE5: engine sends delay request with own t3, its ns in reserved, zero correction
// RULE6: engine's t3 lies less than one second before the real transmit
// RULE7: e2e tc egress writes residence from inserted t3 to real transmit
// RULE8: decryption sits ahead of this stamper, so frames arrive in clear
// RULE9: receive stamp taken at line start of frame, unaffected by security delay
// RULE10: system supplies one shared timetick so all local times run equal
// RULE11: system supplies a global load pulse aligning all local time counters
// RULE12: receive stamp ns part goes into the four reserved header bytes
// RULE13: unmatched frames pass unmodified and their captured stamp is dropped
`timescale 1ns/1ns
module ptp_one_step_stamper (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic timeTickIn,
  input wire logic timeLoadIn,
  input wire logic [47:0] loadSec,
  input wire logic [29:0] loadNs,
  input wire logic [7:0] ptpDomain,
  input wire logic egrEnable,
  input wire logic ingEnable,
  input wire logic egrFullStamp,
  input wire logic egrE2eTc,
  input wire logic ingLineSof,
  input wire logic sysTxValid,
  input wire logic [7:0] sysTxData,
  input wire logic sysTxLast,
  output logic sysTxReady,
  output logic lineTxValid,
  output logic [7:0] lineTxData,
  output logic lineTxLast,
  input wire logic lineTxReady,
  input wire logic lineRxValid,
  input wire logic [7:0] lineRxData,
  input wire logic lineRxLast,
  output logic lineRxReady,
  output logic sysRxValid,
  output logic [7:0] sysRxData,
  output logic sysRxLast,
  input wire logic sysRxReady
);
  // ==========================================================
  // helpers
  // nanosecond sum and difference modulo one second
  function automatic logic [29:0] nsAdd(input logic [29:0] a, input logic [29:0] b);
    logic [30:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, ptp_stamp_pkg::NS_PER_SEC})
    begin
      s = s - {1'b0, ptp_stamp_pkg::NS_PER_SEC};
    end
    return s[29:0];
  endfunction : nsAdd

  function automatic logic [29:0] nsSub(input logic [29:0] a, input logic [29:0] b);
    logic [29:0] r;
    r = a - b;
    if (a < b)
    begin
      r = r + ptp_stamp_pkg::NS_PER_SEC;
    end
    return r;
  endfunction : nsSub

  // ==========================================================
  // local time counter, fed by shared tick and load pins
  logic [2:0] tickSync_q, loadSync_q;
  logic [47:0] sec_q;
  logic [29:0] ns_q;
  logic tickRise, loadRise;

  // three stages; only the last two are compared
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tickSync_q <= '0;
      loadSync_q <= '0;
    end
    else
    begin
      tickSync_q <= {tickSync_q[1:0], timeTickIn};
      loadSync_q <= {loadSync_q[1:0], timeLoadIn};
    end
  end
  assign tickRise = tickSync_q[1] && !tickSync_q[2];
  assign loadRise = loadSync_q[1] && !loadSync_q[2];

  // load beats tick so every device lands on the same value
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sec_q <= '0;
      ns_q <= '0;
    end
    else if (loadRise)
    begin
      sec_q <= loadSec; // see RULE11
      ns_q <= loadNs;
    end
    else if (tickRise)
    begin
      ns_q <= nsAdd(ns_q, ptp_stamp_pkg::TICK_NS); // see RULE10
      if (nsAdd(ns_q, ptp_stamp_pkg::TICK_NS) < ns_q)
      begin
        sec_q <= sec_q + 48'h1;
      end
    end
  end

  // ==========================================================
  // receive stamp caught at the line start of frame pulse
  logic [47:0] rxSec_q;
  logic [29:0] rxNs_q;
  // the pulse comes from ahead of decryption, so security delay never moves it
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rxSec_q <= '0;
      rxNs_q <= '0;
    end
    else if (ingLineSof)
    begin
      rxSec_q <= sec_q; // see RULE9
      rxNs_q <= nsSub(ns_q, ptp_stamp_pkg::ING_LOCAL_CORR_NS);
    end
  end

  // ==========================================================
  // per-direction stream arrays; egress is index 0, ingress 1
  logic [1:0] inValid, inReady, inLast, outReadyExt, dirEnable;
  logic [7:0] inData [2];
  logic [1:0] oValid_q, oLast_q;
  logic [7:0] oData_q [2];

  assign inValid = {lineRxValid, sysTxValid};
  assign inLast = {lineRxLast, sysTxLast};
  assign inData[ptp_stamp_pkg::DIR_EGR] = sysTxData;
  assign inData[ptp_stamp_pkg::DIR_ING] = lineRxData; // see RULE8
  assign outReadyExt = {sysRxReady, lineTxReady};
  assign dirEnable = {ingEnable, egrEnable};
  assign sysTxReady = inReady[ptp_stamp_pkg::DIR_EGR];
  assign lineRxReady = inReady[ptp_stamp_pkg::DIR_ING];
  assign lineTxValid = oValid_q[ptp_stamp_pkg::DIR_EGR];
  assign lineTxData = oData_q[ptp_stamp_pkg::DIR_EGR];
  assign lineTxLast = oLast_q[ptp_stamp_pkg::DIR_EGR];
  assign sysRxValid = oValid_q[ptp_stamp_pkg::DIR_ING];
  assign sysRxData = oData_q[ptp_stamp_pkg::DIR_ING];
  assign sysRxLast = oLast_q[ptp_stamp_pkg::DIR_ING];

  // ingress frames enter already decrypted, in clear form
  for (genvar d = 0; d < 2; d++)
  begin : gDir
    logic fire, pop, popOk, hold, fValid, fLast;
    logic [7:0] fData, newByte;
    logic [8:0] fWord;
    logic [15:0] inCnt_q, outCnt_q, rel;
    logic etHi_q, etOk_q, hdrDone_q, stampValid_q;
    logic [3:0] msg_q;
    logic [31:0] refNs_q, rsvdWord;
    logic [63:0] origCorr_q, newCorr;
    logic [47:0] stSec_q;
    logic [29:0] stNs_q, resid;
    logic [79:0] origin;
    ptp_stamp_pkg::action_t act_q;

    assign fire = inValid[d] && inReady[d];

    stream_fifo #(
      .WIDTH(ptp_stamp_pkg::BYTE_W + 1),
      .DEPTH(ptp_stamp_pkg::FIFO_DEPTH)
    ) uFifo (
      .core_clk(core_clk),
      .rst(rst),
      .inValid(inValid[d]),
      .inReady(inReady[d]),
      .inWord({inLast[d], inData[d]}),
      .outValid(fValid),
      .outReady(popOk),
      .outWord(fWord)
    );
    assign fLast = fWord[8];
    assign fData = fWord[7:0];

    // input side: byte position and header capture as bytes enter
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        inCnt_q <= '0;
        hdrDone_q <= 1'b0;
        etHi_q <= 1'b0;
        etOk_q <= 1'b0;
        msg_q <= '0;
        refNs_q <= '0;
        origCorr_q <= '0;
      end
      else if (fire)
      begin
        inCnt_q <= inLast[d] ? '0 :
          (inCnt_q == ptp_stamp_pkg::CNT_MAX ? inCnt_q : inCnt_q + 16'h1);
        if (inCnt_q == '0)
        begin
          hdrDone_q <= inLast[d];
          etOk_q <= 1'b0;
        end
        else if (inLast[d] || inCnt_q == ptp_stamp_pkg::POS_ORIGIN - 16'h1)
        begin
          hdrDone_q <= 1'b1;
        end
        if (inCnt_q == ptp_stamp_pkg::POS_ETYPE_HI)
        begin
          etHi_q <= (inData[d] == ptp_stamp_pkg::ETYPE_HI);
        end
        if (inCnt_q == ptp_stamp_pkg::POS_ETYPE_LO)
        begin
          etOk_q <= etHi_q && (inData[d] == ptp_stamp_pkg::ETYPE_LO);
        end
        if (inCnt_q == ptp_stamp_pkg::POS_MSGTYPE)
        begin
          msg_q <= inData[d][3:0];
        end
        if (inCnt_q >= ptp_stamp_pkg::POS_CORR && inCnt_q < ptp_stamp_pkg::POS_RSVD)
        begin
          origCorr_q <= {origCorr_q[55:0], inData[d]};
        end
        if (inCnt_q >= ptp_stamp_pkg::POS_RSVD && inCnt_q < ptp_stamp_pkg::POS_ORIGIN)
        begin
          refNs_q <= {refNs_q[23:0], inData[d]}; // see RULE5
        end
      end
    end

    // classification at the domain byte; delay response and others stay nop
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        act_q <= ptp_stamp_pkg::ACT_NOP;
        stampValid_q <= 1'b0;
        stSec_q <= '0;
        stNs_q <= '0;
      end
      else if (fire && inCnt_q == '0)
      begin
        act_q <= ptp_stamp_pkg::ACT_NOP;
        stampValid_q <= 1'b1;
        if (d == ptp_stamp_pkg::DIR_EGR)
        begin
          stSec_q <= sec_q;
          stNs_q <= nsAdd(ns_q, ptp_stamp_pkg::EGR_LATENCY_NS);
        end
        else
        begin
          // a start pulse in the same cycle as byte 0 must beat the older held stamp
          stSec_q <= ingLineSof ? sec_q : rxSec_q;
          stNs_q <= ingLineSof ? nsSub(ns_q, ptp_stamp_pkg::ING_LOCAL_CORR_NS) : rxNs_q;
        end
      end
      else if (fire && inCnt_q == ptp_stamp_pkg::POS_DOMAIN)
      begin
        act_q <= ptp_stamp_pkg::ACT_NOP; // see RULE3
        stampValid_q <= 1'b0; // see RULE13
        if (dirEnable[d] && etOk_q && inData[d] == ptpDomain)
        begin
          if (d == ptp_stamp_pkg::DIR_ING &&
              (msg_q == ptp_stamp_pkg::MSG_SYNC || msg_q == ptp_stamp_pkg::MSG_DELAY_REQ))
          begin
            act_q <= ptp_stamp_pkg::ACT_RSVD; // see RULE2 see RULE4
            stampValid_q <= stampValid_q;
          end
          else if (d == ptp_stamp_pkg::DIR_EGR && msg_q == ptp_stamp_pkg::MSG_SYNC)
          begin
            act_q <= egrFullStamp ? ptp_stamp_pkg::ACT_ORIGIN
                                  : ptp_stamp_pkg::ACT_CORR; // see RULE1
            stampValid_q <= stampValid_q;
          end
          else if (d == ptp_stamp_pkg::DIR_EGR &&
                   msg_q == ptp_stamp_pkg::MSG_DELAY_REQ && egrE2eTc)
          begin
            act_q <= ptp_stamp_pkg::ACT_CORR; // see RULE7
            stampValid_q <= stampValid_q;
          end
        end
      end
    end

    // rewrite values; the inserted t3 is under a second old, so one wrap fixes it
    assign resid = nsSub(stNs_q, refNs_q[29:0]); // see RULE6 see RULE7
    assign newCorr = origCorr_q + {18'h0, resid, 16'h0};
    assign origin = {stSec_q, 2'h0, stNs_q};
    assign rel = outCnt_q - ptp_stamp_pkg::POS_CORR;
    assign rsvdWord = {2'h0, stNs_q};

    // output side: correction bytes wait until the reserved bytes have entered
    assign hold = (outCnt_q == ptp_stamp_pkg::POS_CORR) && (act_q == ptp_stamp_pkg::ACT_CORR)
                  && !hdrDone_q;
    assign popOk = (!oValid_q[d] || outReadyExt[d]) && !hold;
    assign pop = fValid && popOk;

    always_comb
    begin
      newByte = fData;
      if (stampValid_q && act_q == ptp_stamp_pkg::ACT_CORR &&
          outCnt_q >= ptp_stamp_pkg::POS_CORR && outCnt_q < ptp_stamp_pkg::POS_RSVD)
      begin
        newByte = newCorr[(ptp_stamp_pkg::CORR_BYTES - 16'h1 - rel) * 8 +: 8]; // see RULE1
      end
      else if (stampValid_q && act_q == ptp_stamp_pkg::ACT_RSVD &&
               outCnt_q >= ptp_stamp_pkg::POS_RSVD && outCnt_q < ptp_stamp_pkg::POS_ORIGIN)
      begin
        newByte = rsvdWord[(ptp_stamp_pkg::RSVD_BYTES - 16'h1 -
                   (outCnt_q - ptp_stamp_pkg::POS_RSVD)) * 8 +: 8]; // see RULE12
      end
      else if (stampValid_q && act_q == ptp_stamp_pkg::ACT_ORIGIN &&
               outCnt_q >= ptp_stamp_pkg::POS_ORIGIN &&
               outCnt_q < ptp_stamp_pkg::POS_ORIGIN_END)
      begin
        newByte = origin[(ptp_stamp_pkg::ORIGIN_BYTES - 16'h1 -
                  (outCnt_q - ptp_stamp_pkg::POS_ORIGIN)) * 8 +: 8]; // see RULE1
      end
    end

    // output position counter, reset by the last byte
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        outCnt_q <= '0;
      end
      else if (pop)
      begin
        outCnt_q <= fLast ? '0 :
          (outCnt_q == ptp_stamp_pkg::CNT_MAX ? outCnt_q : outCnt_q + 16'h1);
      end
    end

    // registered output stage so data leaves from flops
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        oValid_q[d] <= 1'b0;
        oLast_q[d] <= 1'b0;
        oData_q[d] <= '0;
      end
      else if (pop)
      begin
        oValid_q[d] <= 1'b1;
        oLast_q[d] <= fLast;
        oData_q[d] <= newByte;
      end
      else if (outReadyExt[d])
      begin
        oValid_q[d] <= 1'b0;
      end
    end
  end
endmodule : ptp_one_step_stamper

// *** test/stamper_assertions.sv ***
`timescale 1ns/1ns
// ==========================================================
// port checks for the stamper
module stamper_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sysTxValid,
  input wire logic sysTxReady,
  input wire logic lineTxValid,
  input wire logic [7:0] lineTxData,
  input wire logic lineTxLast,
  input wire logic lineTxReady,
  input wire logic lineRxValid,
  input wire logic lineRxReady,
  input wire logic sysRxValid,
  input wire logic [7:0] sysRxData,
  input wire logic sysRxLast,
  input wire logic sysRxReady
);
  logic [7:0] rxBal_q;
  logic [7:0] txBal_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // bytes inside the ingress path; a drop, repeat or phantom byte skews it
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rxBal_q <= 8'h00;
    else
      rxBal_q <= rxBal_q + 8'(lineRxValid && lineRxReady) - 8'(sysRxValid && sysRxReady);
  end
  // same count for egress
  always_ff @(posedge core_clk)
  begin
    if (rst)
      txBal_q <= 8'h00;
    else
      txBal_q <= txBal_q + 8'(sysTxValid && sysTxReady) - 8'(lineTxValid && lineTxReady);
  end
  a_idle_after_reset: assert property (disable iff (1'b0) rst |=> !lineTxValid && !sysRxValid
    && sysTxReady && lineRxReady) else $error("not idle after reset");
  a_tx_held_byte: assert property (lineTxValid && !lineTxReady |=> lineTxValid
    && $stable(lineTxData) && $stable(lineTxLast)) else $error("line byte changed untaken");
  a_rx_held_byte: assert property (sysRxValid && !sysRxReady |=> sysRxValid
    && $stable(sysRxData) && $stable(sysRxLast)) else $error("system byte changed untaken");
  a_tx_moves_on: assert property (sysTxValid && sysTxReady |-> ##[1:40] lineTxValid)
    else $error("egress byte stuck");
  a_rx_moves_on: assert property (lineRxValid && lineRxReady |-> ##[1:40] sysRxValid)
    else $error("ingress byte stuck");
  a_rx_no_phantom: assert property (sysRxValid |-> rxBal_q != 8'h00)
    else $error("ingress byte from nowhere");
  a_tx_no_phantom: assert property (lineTxValid |-> txBal_q != 8'h00)
    else $error("egress byte from nowhere");
  a_fill_in_range: assert property (rxBal_q <= 8'h12 && txBal_q <= 8'h12)
    else $error("path holds too many bytes");
endmodule : stamper_checker

bind ptp_one_step_stamper stamper_checker stamper_checker_inst (.core_clk, .rst, .sysTxValid,
  .sysTxReady, .lineTxValid, .lineTxData, .lineTxLast, .lineTxReady, .lineRxValid,
  .lineRxReady, .sysRxValid, .sysRxData, .sysRxLast, .sysRxReady);

// *** test/sys_engine_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// system-side engine: sends a frame on go, takes frames, may stall
module sys_engine_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [6:0] txLen,
  input wire logic [7:0] txMem [64],
  input wire logic stall,
  input wire logic rxClear,
  output logic sysTxValid,
  output logic [7:0] sysTxData,
  output logic sysTxLast,
  input wire logic sysTxReady,
  input wire logic sysRxValid,
  input wire logic [7:0] sysRxData,
  input wire logic sysRxLast,
  output logic sysRxReady,
  output logic [7:0] rxMem [64],
  output logic [6:0] rxCnt,
  output logic rxDone
);
  logic [6:0] txIdx_q;
  logic [1:0] ph_q;
  // ==========================================================
  // source: each byte held until taken, frame dropped after its last byte
  always_ff @(posedge core_clk)
  begin
    if (rst || (sysTxValid && sysTxReady && sysTxLast))
    begin
      sysTxValid <= 1'b0;
      txIdx_q <= 7'h00;
    end
    else if (go)
      sysTxValid <= 1'b1;
    else if (sysTxValid && sysTxReady)
      txIdx_q <= txIdx_q + 7'h01;
  end
  // idle data is inverted so a stale byte never looks current
  assign sysTxData = sysTxValid ? txMem[txIdx_q] : ~txMem[txIdx_q];
  assign sysTxLast = sysTxValid && (txIdx_q == txLen - 7'h01);
  // ==========================================================
  // sink: a stalled engine takes one byte in four to back the buffer up
  assign sysRxReady = !stall || (ph_q == 2'h3);
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ph_q <= 2'h0;
    else
      ph_q <= ph_q + 2'h1;
  end
  // capture of received bytes
  always_ff @(posedge core_clk)
  begin
    if (rst || rxClear)
    begin
      rxCnt <= 7'h00;
      rxDone <= 1'b0;
    end
    else if (sysRxValid && sysRxReady)
    begin
      rxMem[rxCnt] <= sysRxData;
      rxCnt <= rxCnt + 7'h01;
      rxDone <= sysRxLast;
    end
  end
endmodule : sys_engine_model

// *** test/tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic timeTickIn = 1'b0;
  logic timeLoadIn = 1'b0;
  logic [47:0] loadSec = 48'h0000_0000_0005;
  logic [29:0] loadNs = 30'h0000_03e8;
  logic [29:0] nowNs;
  logic [7:0] ptpDomain = 8'h03;
  logic egrEnable = 1'b1;
  logic ingEnable = 1'b1;
  logic egrFullStamp = 1'b0;
  logic egrE2eTc = 1'b0;
  logic ingLineSof = 1'b0;
  logic lineRxValid = 1'b0;
  logic lineRxLast = 1'b0;
  logic [7:0] lineRxData = 8'h00;
  logic lineTxReady = 1'b1;
  logic sysTxValid, sysTxLast, sysTxReady, lineTxValid, lineTxLast, lineRxReady;
  logic sysRxValid, sysRxLast, sysRxReady, rxDone;
  logic [7:0] sysTxData, lineTxData, sysRxData;
  logic [7:0] f [64];
  logic [7:0] e [64];
  logic [7:0] lineMem [64];
  logic [7:0] rxMem [64];
  logic [6:0] rxCnt;
  logic [6:0] lnCnt = 7'h00;
  logic [1:0] cyc = 2'h0;
  logic go = 1'b0;
  logic rxClear = 1'b0;
  logic stall = 1'b0;
  logic txStall = 1'b0;
  logic lnDone = 1'b0;
  logic sawFull = 1'b0;
  int error_cnt = 0;
  int comparisons = 0;
  // ==========================================================
  // clock, design and engine
  always #20 core_clk = ~core_clk;
  ptp_one_step_stamper ptp_one_step_stamper_inst (.core_clk, .rst, .timeTickIn, .timeLoadIn,
    .loadSec, .loadNs, .ptpDomain, .egrEnable, .ingEnable, .egrFullStamp, .egrE2eTc,
    .ingLineSof, .sysTxValid, .sysTxData, .sysTxLast, .sysTxReady, .lineTxValid, .lineTxData,
    .lineTxLast, .lineTxReady, .lineRxValid, .lineRxData, .lineRxLast, .lineRxReady,
    .sysRxValid, .sysRxData, .sysRxLast, .sysRxReady);
  sys_engine_model sys_engine_model_inst (.core_clk, .rst, .go, .txLen(7'd60), .txMem(f),
    .stall, .rxClear, .sysTxValid, .sysTxData, .sysTxLast, .sysTxReady, .sysRxValid,
    .sysRxData, .sysRxLast, .sysRxReady, .rxMem, .rxCnt, .rxDone);
  // line sink; when stalled it takes one byte in four
  always @(negedge core_clk)
  begin
    cyc <= cyc + 2'h1;
    lineTxReady <= !txStall || (cyc == 2'h0);
  end
  // capture of the line output and of ingress refusals
  always @(posedge core_clk)
  begin
    if (lineRxValid && !lineRxReady)
      sawFull <= 1'b1;
    if (go)
    begin
      lnCnt <= 7'h00;
      lnDone <= 1'b0;
    end
    else if (lineTxValid && lineTxReady)
    begin
      lineMem[lnCnt] <= lineTxData;
      lnCnt <= lnCnt + 7'h01;
      lnDone <= lineTxLast;
    end
  end
  // ==========================================================
  // helpers
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic timed_out;
    error_cnt++;
    $display("unexpected hang at %0t", $time);
    print_verdict;
  endtask : timed_out
  task automatic put(input int pos, input int n, input logic [63:0] v);
    for (int i = 0; i < n; i++) e[pos + i] = v[8 * (n - 1 - i) +: 8];
  endtask : put
  // frame in f and expected copy in e; type, domain, correction, reserved
  task automatic build(input logic [3:0] msg, input logic [7:0] dom, input logic [63:0] corr,
    input logic [29:0] t3);
    for (int i = 0; i < 64; i++) e[i] = 8'(i * 5 + 1);
    put(12, 2, {48'h0, ptp_stamp_pkg::ETYPE_HI, ptp_stamp_pkg::ETYPE_LO});
    put(14, 1, {60'h0, msg});
    put(18, 1, {56'h0, dom});
    put(22, 8, corr);
    put(30, 4, {34'h0, t3});
    f = e;
  endtask : build
  task automatic check_all(input logic [7:0] got [64]);
    for (int i = 0; i < 60; i++) `CHK(got[i], e[i])
  endtask : check_all
  // line sends f with a start-of-frame pulse, engine must collect it
  task automatic send_line;
    logic r;
    int w;
    @(negedge core_clk);
    rxClear = 1'b1;
    @(negedge core_clk);
    rxClear = 1'b0;
    for (int k = 0; k < 60; k++)
    begin
      @(negedge core_clk);
      ingLineSof = (k == 0);
      lineRxValid = 1'b1;
      lineRxData = f[k];
      lineRxLast = (k == 59);
      for (w = 0; w < 300; w++)
      begin
        #1;
        r = lineRxReady;
        @(posedge core_clk);
        if (r)
          break;
        @(negedge core_clk);
        ingLineSof = 1'b0;
      end
      if (w == 300)
        timed_out;
    end
    @(negedge core_clk);
    {ingLineSof, lineRxValid, lineRxLast} = 3'h0;
    lineRxData = ~lineRxData;
    for (w = 0; w < 3000 && rxDone !== 1'b1; w++) @(posedge core_clk);
    if (w == 3000)
      timed_out;
    #1;
  endtask : send_line
  // engine sends f, line must collect it
  task automatic send_sys;
    int w;
    @(negedge core_clk);
    go = 1'b1;
    @(negedge core_clk);
    go = 1'b0;
    for (w = 0; w < 3000 && lnDone !== 1'b1; w++) @(posedge core_clk);
    if (w == 3000)
      timed_out;
    #1;
  endtask : send_sys
  // ==========================================================
  // scenarios
  task automatic t_ing_stamp;
    stall = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      build(m == 0 ? ptp_stamp_pkg::MSG_SYNC : ptp_stamp_pkg::MSG_DELAY_REQ, 8'h03, 64'h0, 30'h0);
      put(30, 4, {34'h0, nowNs - ptp_stamp_pkg::ING_LOCAL_CORR_NS});
      send_line;
      check_all(rxMem);
    end
    `CHK(sawFull, 1'b1)
    stall = 1'b0;
    $display("ingress stamping done");
  endtask : t_ing_stamp
  task automatic t_pass;
    for (int c = 0; c < 3; c++)
    begin
      build(c == 0 ? 4'h9 : ptp_stamp_pkg::MSG_SYNC, c == 1 ? 8'h04 : 8'h03, 64'h0, 30'h0);
      ingEnable = (c != 2);
      send_line;
      check_all(rxMem);
    end
    ingEnable = 1'b1;
    egrE2eTc = 1'b1;
    build(4'h9, 8'h03, 64'h0, 30'h0);
    send_sys;
    check_all(lineMem);
    $display("pass-through done");
  endtask : t_pass
  task automatic t_egr_full;
    egrFullStamp = 1'b1;
    txStall = 1'b1;
    build(ptp_stamp_pkg::MSG_SYNC, 8'h03, 64'h0, 30'h0);
    put(34, 6, {16'h0, loadSec});
    put(40, 4, {34'h0, nowNs + ptp_stamp_pkg::EGR_LATENCY_NS});
    send_sys;
    check_all(lineMem);
    txStall = 1'b0;
    egrFullStamp = 1'b0;
    $display("egress full stamp done");
  endtask : t_egr_full
  // sync adds to its own correction; delay request t3 sits just before a second rollover
  task automatic t_egr_corr;
    build(ptp_stamp_pkg::MSG_SYNC, 8'h03, 64'h0123_0000, 30'd400);
    put(22, 8, 64'h0123_0000 + (64'(nowNs - 30'd400) << 16));
    send_sys;
    check_all(lineMem);
    build(ptp_stamp_pkg::MSG_DELAY_REQ, 8'h03, 64'h0, 30'h3b9a_c938);
    put(22, 8, 64'(nowNs + 30'd200) << 16);
    send_sys;
    check_all(lineMem);
    $display("egress correction done");
  endtask : t_egr_corr
  // ==========================================================
  // main sequence: reset, align local time, run scenarios
  initial
  begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    timeLoadIn = 1'b1;
    repeat (4) @(negedge core_clk);
    timeLoadIn = 1'b0;
    repeat (3)
    begin
      repeat (4) @(negedge core_clk);
      timeTickIn = 1'b1;
      repeat (4) @(negedge core_clk);
      timeTickIn = 1'b0;
    end
    repeat (8) @(negedge core_clk);
    nowNs = loadNs + 30'h3 * ptp_stamp_pkg::TICK_NS;
    t_ing_stamp;
    t_pass;
    t_egr_full;
    t_egr_corr;
    print_verdict;
  end
endmodule : tb
